//--- hw/tbit_div_if.sv
// Divider chain outputs passed from the counters to the tap selector
`timescale 1ns/10ps
`default_nettype none
interface tbit_div_if;
    logic [tbit_pkg::GEAR_DIV_W-1:0] gearCount;
    logic [tbit_pkg::LOW_DIV_W-1:0]  lowCount;
    modport source (output gearCount, output lowCount);
    modport sink   (input gearCount, input lowCount);
endinterface
`default_nettype wire

//--- hw/tbit_divider.sv
// Free-running gear and low-frequency divider chains
`timescale 1ns/10ps
`default_nettype none
module tbit_divider (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  rst_n,
    // Low-frequency clock, sampled as a level
    input  wire logic  low_frequency_clock,
    // Divider outputs
    tbit_div_if.source div
);
    logic lowSync1;
    logic lowSync2;
    logic lowPrev;
    logic lowRise;

    // Edge is taken from the second stage only
    assign lowRise = lowSync2 & ~lowPrev;

    // Chains never stop or reload, so enabling keeps their phase (R7)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div.gearCount <= '0;
            div.lowCount  <= '0;
            lowSync1      <= 1'b0;
            lowSync2      <= 1'b0;
            lowPrev       <= 1'b0;
        end else begin
            div.gearCount <= div.gearCount + 1'b1; // (R7)
            lowSync1      <= low_frequency_clock;
            lowSync2      <= lowSync1;
            lowPrev       <= lowSync2;
            // Resynchronising costs up to one gear cycle of jitter (R12)
            if (lowRise) begin
                div.lowCount <= div.lowCount + 1'b1; // (R7)
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/tbit_pkg.sv
// Constants shared by the time base interval timer files
package tbit_pkg;
    // Divider chain and exponent widths
    localparam int unsigned GEAR_DIV_W  = 22;
    localparam int unsigned LOW_DIV_W   = 15;
    localparam int unsigned EXP_W       = 5;
    // Register indexes; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX    = 8'h39;
    localparam logic [7:0]  STAT_IDX    = 8'h3a;
    localparam logic [7:0]  MASK_IDX    = 8'h3b;
    // Control register fields and reset
    localparam int unsigned EN_BIT      = 3;
    localparam int unsigned RATE_LSB    = 0;
    localparam int unsigned RATE_W      = 3;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    // Status and mask register layout and reset
    localparam int unsigned TICK_BIT    = 0;
    localparam logic        STAT_RESET  = 1'b0;
    localparam logic        MASK_RESET  = 1'b0;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Divide exponent per rate code; zero marks a reserved code
    localparam logic [4:0]  GEAR_EXP [8] = '{5'h16, 5'h14, 5'h0f, 5'h0d,
                                             5'h0c, 5'h0b, 5'h0a, 5'h08};
    localparam logic [4:0]  LOW_EXP  [8] = '{5'h0f, 5'h0d, 5'h08, 5'h06,
                                             5'h05, 5'h04, 5'h03, 5'h00};
    // Codes usable while running from the low-frequency clock only
    localparam logic [2:0]  SLOW_LAST_CODE = 3'h1;
endpackage

//--- hw/tbit_tap_select.sv
// Rate tap selection and falling edge detection
`timescale 1ns/10ps
`default_nettype none
module tbit_tap_select (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Divider chain
    tbit_div_if.sink        div,
    // Mode and selection
    input  wire logic       slowMode,
    input  wire logic       slow_divider_select,
    input  wire logic [2:0] rateSel,
    // Falling edge of the chosen tap, one cycle
    output logic            tapFall
);
    logic [4:0] gearExp;
    logic [4:0] lowExp;
    logic [4:0] gearBit;
    logic [4:0] lowBit;
    logic       lowCodeOk;
    logic       useLow;
    logic       gearTap;
    logic       lowTap;
    logic       selTap;
    logic       tapNow;
    logic       tapPrev;

    assign gearExp   = tbit_pkg::GEAR_EXP[rateSel];
    assign lowExp    = tbit_pkg::LOW_EXP[rateSel];
    // Bit n-1 of a counter has a period of 2^n input cycles
    assign gearBit   = gearExp - 5'h01;
    assign lowBit    = lowExp - 5'h01;
    assign gearTap   = div.gearCount[gearBit]; // (R3)
    assign lowTap    = div.lowCount[lowBit[3:0]]; // (R4)
    // Reserved codes hold the tap low so no edge appears (R4) (R5)
    assign lowCodeOk = slowMode ? (rateSel <= tbit_pkg::SLOW_LAST_CODE)
                                : (lowExp != 5'h00);
    assign useLow    = slowMode | slow_divider_select; // (R5)
    assign selTap    = useLow ? (lowCodeOk & lowTap) : gearTap;
    assign tapFall   = tapPrev & ~tapNow; // (R14)

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tapNow  <= 1'b0;
            tapPrev <= 1'b0;
        end else begin
            tapNow  <= selTap;
            tapPrev <= tapNow;
        end
    end
endmodule
`default_nettype wire

//--- hw/tbit_timer.sv
// Time base interval timer with AXI4-Lite registers and interrupt
//
// How it works
// (R1) Control: enable bit 3, rate bits 2:0
// (R2) Enable low blocks requests, high allows them
// (R3) Gear clock taps 2^22 down to 2^8
// (R4) Low clock taps 2^15..2^3, code 7 reserved
// (R5) Slow modes: codes 0,1 only, rest reserved
// (R6) Request at every falling edge of tap
// (R7) Divider runs regardless of enable
// (R8) First request at first falling edge
// (R9) STOP entry clears enable, keeps rate
// (R10) Software changes rate only while disabled
// (R11) Software switches speed only while disabled
// (R12) Low clock resync may jitter request timing
// (R13) Upper control bits 7:4 read zero
// (R14) Request is a one-cycle synchronous pulse
`timescale 1ns/10ps
`default_nettype none
module tbit_timer #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // AXI4-Lite read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Clock source and operating mode
    input  wire logic              low_frequency_clock,
    input  wire logic              slow_divider_select,
    input  wire logic              slowMode,
    input  wire logic              stopEntry,
    // Requests
    output logic                   tick_interrupt_request,
    output logic                   irq
);
    localparam int unsigned IDX_W = ADDR_W - 2;

    // Control and status state
    logic                              tick_request_enable;
    logic [tbit_pkg::RATE_W-1:0]       tick_rate_select;
    logic                              tickPending;
    logic                              tickMask;
    logic                              tapFall;

    // Write channel state
    logic                    awHeld;
    logic [ADDR_W-1:0]       awAddrHeld;
    logic                    wHeld;
    logic [31:0]             wDataHeld;
    logic [3:0]              wStrbHeld;

    // Decode
    logic [IDX_W-1:0]        wrIdx;
    logic [IDX_W-1:0]        rdIdx;
    logic                    wrFire;
    logic                    wrLane0;
    logic                    wrCtrl;
    logic                    wrStat;
    logic                    wrMask;
    logic                    wrHit;
    logic                    rdFire;
    logic                    rdCtrl;
    logic                    rdStat;
    logic                    rdMask;
    logic                    rdHit;
    logic [31:0]             rdMux;
    logic [7:0]              ctrlView;

    // Next values
    logic                              next_enable;
    logic [tbit_pkg::RATE_W-1:0]       next_rate;
    logic                              next_pending;
    logic                              tickEvent;
    logic                              clearTick;

    tbit_div_if divBus ();

    tbit_divider u_divider (
        .mclk                (mclk),
        .rst_n               (rst_n),
        .low_frequency_clock (low_frequency_clock),
        .div                 (divBus)
    );

    tbit_tap_select u_tap (
        .mclk                (mclk),
        .rst_n               (rst_n),
        .div                 (divBus),
        .slowMode            (slowMode),
        .slow_divider_select (slow_divider_select),
        .rateSel             (tick_rate_select),
        .tapFall             (tapFall)
    );

    // Address and data are taken in either order, one write at a time
    assign awready = ~awHeld & ~bvalid;
    assign wready  = ~wHeld & ~bvalid;
    assign wrFire  = awHeld & wHeld & ~bvalid;
    assign wrIdx   = awAddrHeld[ADDR_W-1:2];
    assign wrLane0 = wrFire & wStrbHeld[0];
    assign wrCtrl  = wrIdx == IDX_W'(tbit_pkg::CTRL_IDX);
    assign wrStat  = wrIdx == IDX_W'(tbit_pkg::STAT_IDX);
    assign wrMask  = wrIdx == IDX_W'(tbit_pkg::MASK_IDX);
    assign wrHit   = wrCtrl | wrStat | wrMask;

    assign arready = ~rvalid;
    assign rdFire  = arvalid & ~rvalid;
    assign rdIdx   = araddr[ADDR_W-1:2];
    assign rdCtrl  = rdIdx == IDX_W'(tbit_pkg::CTRL_IDX);
    assign rdStat  = rdIdx == IDX_W'(tbit_pkg::STAT_IDX);
    assign rdMask  = rdIdx == IDX_W'(tbit_pkg::MASK_IDX);
    assign rdHit   = rdCtrl | rdStat | rdMask;

    // Upper control bits are not stored and read as zero
    assign ctrlView = {4'h0, tick_request_enable, tick_rate_select}; // (R13)
    assign rdMux    = rdCtrl ? {24'h00_0000, ctrlView} // (R1)
                    : rdStat ? {31'h0000_0000, tickPending}
                    : rdMask ? {31'h0000_0000, tickMask}
                    : 32'h0000_0000;

    // STOP entry wins over a software write in the same cycle
    assign next_enable = stopEntry ? 1'b0 // (R9)
                       : (wrLane0 & wrCtrl) ? wdata_en(wDataHeld) // (R1)
                       : tick_request_enable;
    // Rate is not touched by STOP entry; changing it while enabled
    // may give one stray edge, which software avoids
    assign next_rate   = (wrLane0 & wrCtrl)
                       ? wDataHeld[tbit_pkg::RATE_LSB +: tbit_pkg::RATE_W]
                       : tick_rate_select; // (R9) (R10)

    // Edges before enabling are ignored, so the first one after it
    // may come early in the period (R8)
    assign tickEvent    = tapFall & tick_request_enable; // (R2) (R6) (R8)
    assign clearTick    = wrLane0 & wrStat & wDataHeld[tbit_pkg::TICK_BIT];
    // A new tick in the clearing cycle keeps the bit set
    assign next_pending = tickEvent | (tickPending & ~clearTick);

    assign irq = tickPending & tickMask;

    function automatic logic wdata_en(input logic [31:0] d);
        return d[tbit_pkg::EN_BIT];
    endfunction

    // Control register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_request_enable <= tbit_pkg::CTRL_RESET[tbit_pkg::EN_BIT];
            tick_rate_select    <= tbit_pkg::CTRL_RESET[2:0]; // (R1)
        end else begin
            tick_request_enable <= next_enable;
            tick_rate_select    <= next_rate;
        end
    end

    // Request pulse, status and mask
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_interrupt_request <= 1'b0;
            tickPending            <= tbit_pkg::STAT_RESET;
            tickMask               <= tbit_pkg::MASK_RESET;
        end else begin
            tick_interrupt_request <= tickEvent; // (R14)
            tickPending            <= next_pending;
            if (wrLane0 & wrMask) begin
                tickMask <= wDataHeld[tbit_pkg::TICK_BIT];
            end
        end
    end

    // Write address and data holding
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld     <= 1'b0;
            awAddrHeld <= '0;
            wHeld      <= 1'b0;
            wDataHeld  <= 32'h0000_0000;
            wStrbHeld  <= 4'h0;
        end else if (wrFire) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
        end else begin
            if (awvalid & awready) begin
                awHeld     <= 1'b1;
                awAddrHeld <= awaddr;
            end
            if (wvalid & wready) begin
                wHeld     <= 1'b1;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= tbit_pkg::RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? tbit_pkg::RESP_OKAY : tbit_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= tbit_pkg::RESP_OKAY;
        end else if (rdFire) begin
            rvalid <= 1'b1;
            rdata  <= rdMux;
            rresp  <= rdHit ? tbit_pkg::RESP_OKAY : tbit_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Register and tick regression for the time base interval timer
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [11:0] A_CTRL = 12'h0e4;
    localparam logic [11:0] A_STAT = 12'h0e8;
    localparam logic [11:0] A_MASK = 12'h0ec;
    localparam logic [11:0] A_NONE = 12'h010;
    localparam int          GEXP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
    logic        mclk = 1'h0, rst_n = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        low_frequency_clock = 1'h0, slow_divider_select = 1'h0;
    logic        slowMode = 1'h0, stopEntry = 1'h0, tick_interrupt_request;
    int          errorCnt = 0, nTests = 0, cyc = 0, n, base, tLast, cnt;

    tbit_timer i_dut (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .low_frequency_clock, .slow_divider_select, .slowMode, .stopEntry,
        .tick_interrupt_request, .irq);
    tbit_irq_ctrl i_ic (.mclk, .rst_n, .req(tick_interrupt_request),
        .reqCount(cnt));

    always #5 mclk = ~mclk;
    // Low clock of four cycles keeps the slow-mode code 1 rate within the run
    always #20 low_frequency_clock = ~low_frequency_clock;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errorCnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Handshake state is sampled at the falling edge, where it is settled
    task automatic axw(input logic [11:0] a, input logic [31:0] dd);
        logic ta, tw, tb;
        @(posedge mclk);
        awaddr <= a;
        wdata <= dd;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        tb = 1'h0;
        while (!tb) begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask
    task automatic axr(input logic [11:0] a);
        logic tk, rv;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        rv = 1'h0;
        while (!rv) begin
            @(negedge mclk);
            tk = arvalid && arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (tk) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dd);
        axw(a, dd);
        chk("bresp", r, tbit_pkg::RESP_OKAY);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] e);
        axr(a);
        chk(what, d, e);
    endtask
    task automatic next_tick();
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (tick_interrupt_request !== 1'h1 && n < 40000);
    endtask
    task automatic quiet(input string what, input int cycles);
        base = cnt;
        repeat (cycles) @(posedge mclk);
        chk(what, cnt, base);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'h1;
        rdchk("ctrl reset", A_CTRL, 32'h0);
        rdchk("stat reset", A_STAT, 32'h0);
        rdchk("mask reset", A_MASK, 32'h0);
        wr(A_CTRL, 32'h0000_00ff);
        rdchk("ctrl upper", A_CTRL, 32'h0000_000f);
        wstrb <= 4'he;
        wr(A_CTRL, 32'h0);
        wstrb <= 4'hf;
        rdchk("ctrl strobe", A_CTRL, 32'h0000_000f);
        axw(A_NONE, 32'h1);
        chk("bad write", r, tbit_pkg::RESP_SLVERR);
        rdchk("bad read", A_NONE, 32'h0);
        chk("bad rresp", r, tbit_pkg::RESP_SLVERR);
        $display("Registers test done");
        next_tick();
        tLast = cyc;
        next_tick();
        chk("period 7", n, 256);
        wr(A_CTRL, 32'h7);
        repeat (100) @(posedge mclk);
        wr(A_CTRL, 32'hf);
        next_tick();
        chk("first short", n <= 259, 1);
        chk("phase kept", (cyc - tLast) % 256, 0);
        rdchk("stat set", A_STAT, 32'h1);
        wr(A_MASK, 32'h1);
        chk("irq on", irq, 1'h1);
        wr(A_CTRL, 32'h7);
        repeat (5) @(posedge mclk);
        wr(A_STAT, 32'h1);
        chk("irq off", irq, 1'h0);
        quiet("disabled", 600);
        rdchk("stat clear", A_STAT, 32'h0);
        $display("Tick and interrupt test done");
        wr(A_CTRL, 32'hf);
        @(posedge mclk);
        stopEntry <= 1'h1;
        @(posedge mclk);
        stopEntry <= 1'h0;
        rdchk("stop", A_CTRL, 32'h7);
        quiet("stopped", 600);
        for (int c = 3; c < 7; c++) begin
            wr(A_CTRL, c);
            wr(A_CTRL, c | 8);
            next_tick();
            next_tick();
            chk("gear period", n, 1 << GEXP[c]);
            wr(A_CTRL, c);
        end
        $display("Gear rate test done");
        slow_divider_select <= 1'h1;
        wr(A_CTRL, 32'h6);
        wr(A_CTRL, 32'he);
        next_tick();
        next_tick();
        chk("low period", n >= 31 && n <= 33, 1);
        wr(A_CTRL, 32'h7);
        wr(A_CTRL, 32'hf);
        quiet("low reserved", 500);
        wr(A_CTRL, 32'h7);
        slowMode <= 1'h1;
        // Code 6 ticks every 32 cycles in normal mode, so a leak shows
        wr(A_CTRL, 32'h6);
        wr(A_CTRL, 32'he);
        quiet("slow reserved", 500);
        wr(A_CTRL, 32'h1);
        // Slow mode alone must pick the low clock taps
        slow_divider_select <= 1'h0;
        wr(A_CTRL, 32'h9);
        next_tick();
        chk("slow tick", n <= 32800, 1);
        $display("Low clock test done");
        tally_and_finish();
    end
endmodule
bind tbit_timer tbit_asserts i_chk (.mclk, .rst_n, .awready, .wready,
    .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
    .rresp, .tick_interrupt_request);
`default_nettype wire

//--- verification/tbit_asserts.sv
// Bus handshake and request checks for the time base interval timer
`timescale 1ns/10ps
`default_nettype none
module tbit_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Bus handshakes
    input wire logic        awready,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    // Request
    input wire logic        tick_interrupt_request
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_take; arvalid && arready; endsequence
    sequence s_rd_wait; rvalid && !rready; endsequence
    sequence s_tick; tick_interrupt_request; endsequence
    property p_rd_lat; s_rd_take |=> rvalid; endproperty
    property p_rd_hold; s_rd_wait |=> rvalid && $stable(rdata); endproperty
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_ar_ready; arready == !rvalid; endproperty
    property p_w_block; bvalid |-> !awready && !wready; endproperty
    property p_err_data; rvalid && rresp == 2'h2 |-> rdata == 32'h0;
    endproperty
    property p_hi_zero; rvalid |-> rdata[31:4] == 28'h0; endproperty
    property p_tick; s_tick |=> !tick_interrupt_request [*8]; endproperty
    property p_resp; bvalid |-> bresp == 2'h0 || bresp == 2'h2; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_b_hold: assert property (p_b_hold) else $error("write answer moved");
    a_ar_ready: assert property (p_ar_ready) else $error("arready wrong");
    a_w_block: assert property (p_w_block) else $error("write not blocked");
    a_err_data: assert property (p_err_data) else $error("error data set");
    a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
    a_tick: assert property (p_tick) else $error("request too long");
    a_resp: assert property (p_resp) else $error("bad write answer");
endmodule
`default_nettype wire

//--- verification/tbit_irq_ctrl.sv
// Interrupt controller model counting periodic requests
`timescale 1ns/10ps
`default_nettype none
module tbit_irq_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Request from the timer
    input wire logic req,
    output int       reqCount
);
    // Counts per cycle, so a stretched pulse shows up as extra requests
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) reqCount <= 0;
        else if (req) reqCount <= reqCount + 1;
    end
endmodule
`default_nettype wire
